// file: core/shrp_port.sv
// Serial host register port: frame receiver, register map and read-back shifter.
// How it works
// - A frame is sixteen bits on serial_in, sampled at serial clock rising edges.
// - Write data waits after sixteen clocks and commits when chip select rises.
// - Bit one chooses the operation: low writes, high reads.
// - Bits two to seven carry the address, bit zero first.
// - Bit eight is a dummy, ignored, giving time to prepare read data.
// - Bits nine to sixteen carry write data, bit zero first.
// - Reads drive serial_out at falling edges eight to fifteen, bit zero first.
// - Reset pin low over ten milliseconds restores all register defaults.
// - Interrupt enable holds five masks at bits four to zero, reset zero.
// - Oscillator lock interrupt enable works only with lock detect enabled.
// - Control and status at addresses zero to five; six to 0x3D reserved.
// - Read-only device identity at 0x3E and revision identity at 0x3F.
// - Status bits set on source change, the oscillator bit only with lock detect enabled, clear on read; interrupt enable gates only the interrupt pin.
// - Live status shows loss, recovery lock, multiplier lock unlatched.
`timescale 1ns/10ps
module shrp_port
  import shrp_pkg::*;
#(
  parameter logic [7:0] DEVICE_IDENTITY = 8'hA5, // Arbitrary value.
  parameter logic [7:0] REVISION_IDENTITY = 8'h01, // Arbitrary value.
  parameter int RESET_HOLD = RESET_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host serial pins.
  input wire logic chipSelect_n,
  input wire logic serialClock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serialOutEn,
  input wire logic resetPin_n,
  // Status sources from the transceiver.
  input wire logic osc_locked,
  input wire logic sig_loss_now,
  input wire logic recovery_locked,
  input wire logic multiplier_locked,
  input wire logic overflow_now,
  // Interrupt and control outputs.
  output logic interrupt_n,
  output logic [7:0] clockFifoControl,
  output logic [7:0] timingPolarityControl,
  output logic [7:0] loopbackControl
);
  // Synchronised pins and sources.
  logic csSync, sclkSync, sdiSync, resetLowSync;
  logic [4:0] srcSync;
  logic sclkPrev, softReset, regReset;
  shrp_state_t state;
  logic [4:0] bitCount;
  logic [15:0] frame;
  logic [7:0] interruptEnable, interruptStatus, readShift;
  logic readFrame;
  logic [4:0] srcPrev;
  logic [7:0] next_status;

  shrp_sync #(.WIDTH(3), .INIT(3'h1)) uPinSync (
    .clk(ref_clk), .rst(rst),
    .asyncIn({serialClock, serial_in, chipSelect_n}),
    .syncOut({sclkSync, sdiSync, csSync})
  );
  // The reset pin starts at its idle level so that no low time is counted after reset.
  shrp_sync #(.WIDTH(6), .INIT(6'h00)) uSrcSync (
    .clk(ref_clk), .rst(rst),
    .asyncIn({~resetPin_n, osc_locked, sig_loss_now, recovery_locked, multiplier_locked, overflow_now}),
    .syncOut({resetLowSync, srcSync})
  );
  shrp_reset_filter #(.HOLD_CYCLES(RESET_HOLD)) uResetFilter (
    .clk(ref_clk), .rst(rst),
    .resetPinLowSync(resetLowSync),
    .softReset(softReset)
  );

  // Edge detection of the sampled serial clock.
  wire sclkRise = sclkSync & ~sclkPrev;
  wire sclkFall = ~sclkSync & sclkPrev;
  wire selected = ~csSync;
  assign regReset = rst | softReset;

  // Frame fields; bit one arrives first and lands at frame[0].
  wire isRead = frame[0];
  wire [5:0] frameAddr = frame[6:1];
  wire [7:0] frameData = frame[15:8];
  wire frameDone = (state == SHRP_FULL);
  // Commit only when chip select rises after a complete frame.
  wire commit = frameDone & csSync & ~isRead;
  // At the eighth rising edge seven bits have shifted in, so the read flag sits at frame[9].
  wire readNow = (state == SHRP_SHIFT) & sclkRise & (bitCount == BIT_ADDR_LAST) & frame[9];

  // Address decode of the full frame.
  wire hitEnable = commit & (frameAddr == ADDR_INTERRUPT_ENABLE);
  wire hitClockFifo = commit & (frameAddr == ADDR_CLOCK_FIFO_CONTROL);
  wire hitTiming = commit & (frameAddr == ADDR_TIMING_POLARITY_CONTROL);
  wire hitLoopback = commit & (frameAddr == ADDR_LOOPBACK_CONTROL);
  // The address is fully known after bit seven, so read data is chosen at the dummy bit.
  wire [5:0] readAddr = frame[15:10];
  // Output slots are the falling edges that follow rising edges eight to fifteen.
  wire readSlot = sclkFall & readFrame & (bitCount >= BIT_DUMMY) & (bitCount < BIT_DATA_LAST);
  wire statusReadTaken = readNow & (readAddr == ADDR_INTERRUPT_STATUS);

  // Live status; reserved and unlisted bits read zero.
  wire [7:0] liveStatus = {3'h0, srcSync[4] & timingPolarityControl[POS_OSC_LOCK_DETECT_EN],
    srcSync[3], srcSync[2], srcSync[1], srcSync[0]};

  // Read multiplexer for the register map.
  function automatic logic [7:0] readMux(input logic [5:0] addr);
    unique case (addr)
      ADDR_INTERRUPT_ENABLE: readMux = interruptEnable;
      ADDR_INTERRUPT_STATUS: readMux = interruptStatus;
      ADDR_LIVE_STATUS: readMux = liveStatus;
      ADDR_CLOCK_FIFO_CONTROL: readMux = clockFifoControl;
      ADDR_TIMING_POLARITY_CONTROL: readMux = timingPolarityControl;
      ADDR_LOOPBACK_CONTROL: readMux = loopbackControl;
      ADDR_DEVICE_IDENTITY: readMux = DEVICE_IDENTITY;
      ADDR_REVISION_IDENTITY: readMux = REVISION_IDENTITY;
      default: readMux = 8'h00;
    endcase
  endfunction : readMux

  // Source change events; the oscillator event counts only with detection on.
  wire [4:0] srcChange = srcSync ^ srcPrev;
  wire [7:0] events = {3'h0, srcChange[4] & timingPolarityControl[POS_OSC_LOCK_DETECT_EN], srcChange[3:0]};

  // Clear-on-read takes the sampled value; a new event in the same cycle wins.
  always_comb begin
    next_status = interruptStatus;
    if (statusReadTaken) begin
      next_status = 8'h00;
    end
    next_status = next_status | events;
  end

  // Effective enable mask, the oscillator bit gated by lock detect enable.
  wire [7:0] effEnable = {interruptEnable[7:5], interruptEnable[4] & timingPolarityControl[POS_OSC_LOCK_DETECT_EN],
    interruptEnable[3:0]};
  wire next_irq = |(next_status & effEnable);

  // Frame receiver: count bits on rising edges; chip select high aborts.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SHRP_IDLE;
      bitCount <= 5'h00;
      frame <= 16'h0000;
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= sclkSync;
      unique case (state)
        SHRP_IDLE: begin
          if (selected) begin
            state <= SHRP_SHIFT;
            bitCount <= 5'h00;
          end
        end
        SHRP_SHIFT: begin
          if (!selected) begin
            state <= SHRP_IDLE;
          end else if (sclkRise) begin
            frame <= {sdiSync, frame[15:1]};
            bitCount <= bitCount + 5'h01;
            if (bitCount == BIT_DATA_LAST - 5'h01) begin
              state <= SHRP_FULL;
            end
          end
        end
        SHRP_FULL: begin
          // Extra clocks are ignored until chip select rises.
          if (!selected) begin
            state <= SHRP_IDLE;
          end
        end
      endcase
    end
  end

  // Register file; reset pin held long enough restores defaults.
  always_ff @(posedge ref_clk) begin
    if (regReset) begin
      interruptEnable <= RESET_REGISTER;
      interruptStatus <= RESET_REGISTER;
      clockFifoControl <= RESET_REGISTER;
      timingPolarityControl <= RESET_REGISTER;
      loopbackControl <= RESET_REGISTER;
      srcPrev <= 5'h00;
      interrupt_n <= 1'b1;
    end else begin
      srcPrev <= srcSync;
      interruptStatus <= next_status;
      interrupt_n <= ~next_irq;
      if (hitEnable) begin
        interruptEnable <= frameData & MASK_INTERRUPT_ENABLE;
      end
      if (hitClockFifo) begin
        clockFifoControl <= frameData & MASK_CLOCK_FIFO_CONTROL;
      end
      if (hitTiming) begin
        timingPolarityControl <= frameData & MASK_TIMING_POLARITY_CONTROL;
      end
      if (hitLoopback) begin
        loopbackControl <= frameData & MASK_LOOPBACK_CONTROL;
      end
    end
  end

  // Read shifter: loaded at the dummy bit, bits out at falling edges eight to fifteen.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readShift <= 8'h00;
      readFrame <= 1'b0;
      serial_out <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (!selected) begin
      readFrame <= 1'b0;
      serial_out <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (readNow) begin
      readShift <= readMux(readAddr);
      readFrame <= 1'b1;
    end else if (readSlot) begin
      serial_out <= readShift[0];
      serialOutEn <= 1'b1;
      readShift <= {1'b0, readShift[7:1]};
    end
  end
endmodule : shrp_port

// file: core/shrp_pkg.sv
// Constants and types shared by the serial host register port.
package shrp_pkg;
  // Frame layout, counted in serial clocks.
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] BIT_RW = 5'h01;
  localparam logic [4:0] BIT_ADDR_FIRST = 5'h02;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_DUMMY = 5'h08;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h09;
  localparam logic [4:0] BIT_DATA_LAST = 5'h10;
  // Register addresses.
  localparam logic [5:0] ADDR_INTERRUPT_ENABLE = 6'h00;
  localparam logic [5:0] ADDR_INTERRUPT_STATUS = 6'h01;
  localparam logic [5:0] ADDR_LIVE_STATUS = 6'h02;
  localparam logic [5:0] ADDR_CLOCK_FIFO_CONTROL = 6'h03;
  localparam logic [5:0] ADDR_TIMING_POLARITY_CONTROL = 6'h04;
  localparam logic [5:0] ADDR_LOOPBACK_CONTROL = 6'h05;
  localparam logic [5:0] ADDR_DEVICE_IDENTITY = 6'h3E;
  localparam logic [5:0] ADDR_REVISION_IDENTITY = 6'h3F;
  // Writable bit masks and reset values.
  localparam logic [7:0] MASK_INTERRUPT_ENABLE = 8'h1F;
  localparam logic [7:0] MASK_CLOCK_FIFO_CONTROL = 8'h5F;
  localparam logic [7:0] MASK_TIMING_POLARITY_CONTROL = 8'h7D;
  localparam logic [7:0] MASK_LOOPBACK_CONTROL = 8'h07;
  localparam logic [7:0] RESET_REGISTER = 8'h00;
  // Field positions.
  localparam int POS_OSC_LOCK = 4;
  localparam int POS_SIG_LOSS = 3;
  localparam int POS_RECOVERY_LOCK = 2;
  localparam int POS_MULTIPLIER_LOCK = 1;
  localparam int POS_OVERFLOW = 0;
  localparam int POS_OSC_LOCK_DETECT_EN = 0;
  // Reset pin must be held low longer than this.
  localparam int RESET_HOLD_MS = 10;
  localparam int CLOCK_MHZ = 125;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * CLOCK_MHZ + 1;
  localparam int CNT_W = 21;
  // Frame receiver states.
  typedef enum logic [1:0] {SHRP_IDLE, SHRP_SHIFT, SHRP_FULL} shrp_state_t;
endpackage : shrp_pkg

// file: core/shrp_sync.sv
// Two-flop synchroniser for asynchronous inputs.
`timescale 1ns/10ps
module shrp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, synchronous out.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= INIT;
      syncOut <= INIT;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : shrp_sync

// file: core/shrp_reset_filter.sv
// Qualifies the active-low reset pin by its minimum hold time.
`timescale 1ns/10ps
module shrp_reset_filter
  import shrp_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Synchronised pin level and qualified reset.
  input wire logic resetPinLowSync,
  output logic softReset
);
  logic [CNT_W-1:0] holdCount;
  wire holdDone = (holdCount >= CNT_W'(HOLD_CYCLES));

  // Count while the pin stays low; a short glitch never reaches the registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      holdCount <= '0;
      softReset <= 1'b0;
    end else begin
      holdCount <= resetPinLowSync ? (holdDone ? holdCount : holdCount + 1'b1) : '0;
      softReset <= resetPinLowSync & holdDone;
    end
  end
endmodule : shrp_reset_filter

// file: verif/shrp_port_properties.sv
// Port checks for the serial host register port.
`timescale 1ns/10ps
module shrp_port_properties
  import shrp_pkg::*;
#(parameter int RESET_HOLD = 100) (
  // All ports of the port block.
  input wire logic ref_clk, rst, chipSelect_n, serialClock, serial_in, serial_out, serialOutEn, resetPin_n,
  input wire logic osc_locked, sig_loss_now, recovery_locked, multiplier_locked, overflow_now, interrupt_n,
  input wire logic [7:0] clockFifoControl, timingPolarityControl, loopbackControl
);
  // Low time of the reset pin, saturated so that it never wraps.
  int lowCnt;
  wire logic [23:0] ctrlAll = {clockFifoControl, timingPolarityControl, loopbackControl};
  always_ff @(posedge ref_clk) begin
    if (rst || resetPin_n) lowCnt <= 0;
    else if (lowCnt < RESET_HOLD + 20) lowCnt <= lowCnt + 1;
  end
  // All checks share one clock and the block reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_reset_values; $fell(rst) |-> ctrlAll == 24'h000000 && interrupt_n && !serialOutEn; endproperty
  a_reset_values: assert property (p_reset_values) else $error("outputs not at reset values");
  property p_idle_low; !serialOutEn |-> !serial_out; endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial output not idle");
  property p_en_drop; $rose(chipSelect_n) |-> ##[1:5] !serialOutEn; endproperty
  a_en_drop: assert property (p_en_drop) else $error("serial output kept after frame");
  property p_en_start; $rose(serialOutEn) |-> !chipSelect_n && !serialClock; endproperty
  a_en_start: assert property (p_en_start) else $error("serial output started outside frame");
  property p_sdo_edge; serialOutEn && $changed(serial_out) |-> !serialClock; endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("read bit moved while clock high");
  // A commit may only follow a chip select that has been high for a while.
  property p_commit_cs; $changed(ctrlAll) && resetPin_n |-> chipSelect_n && $past(chipSelect_n, 2); endproperty
  a_commit_cs: assert property (p_commit_cs) else $error("control changed inside frame");
  property p_reserved_zero;
    (clockFifoControl & 8'hA0) == 8'h00 && (timingPolarityControl & 8'h82) == 8'h00 && loopbackControl[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bit set");
  property p_pin_reset; lowCnt == RESET_HOLD + 10 |-> ctrlAll == 24'h000000; endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not clear controls");
  c_read: cover property ($rose(serialOutEn));
  c_irq: cover property ($fell(interrupt_n));
  c_pin: cover property (lowCnt == RESET_HOLD + 10);
endmodule : shrp_port_properties

// file: verif/shrp_host_model.sv
// Behavioural host processor on the four-wire serial port.
`timescale 1ns/10ps
module shrp_host_model (
  // Serial pins.
  output logic chipSelect_n, serialClock, serial_in,
  input wire logic serial_out
);
  // Clock stands low and select high between frames.
  initial begin
    chipSelect_n = 1'b1;
    serialClock = 1'b0;
    serial_in = 1'b0;
  end
  // One access per select; a count below sixteen cuts the frame short.
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d, input int n, output logic [7:0] q);
    logic [15:0] frame;
    frame = {d, ~serial_in, a, rd};
    q = 8'h00;
    chipSelect_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      serial_in = frame[i];
      #40 serialClock = 1'b1;
      if (i >= 8) q[i-8] = serial_out;
      #40 serialClock = 1'b0;
    end
    #40 chipSelect_n = 1'b1;
    // The released data line shows the inverse so stale values cannot pass.
    serial_in = ~serial_in;
    #80;
  endtask : xfer
endmodule : shrp_host_model

// file: verif/shrp_port_tb.sv
// Self-checking bench for the serial host register port.
`timescale 1ns/10ps
module shrp_port_tb;
  import shrp_pkg::*;
  localparam int HOLD = 100;
  logic ref_clk, rst, chipSelect_n, serialClock, serial_in, serial_out, serialOutEn, resetPin_n, interrupt_n;
  logic [4:0] src;
  logic [7:0] clockFifoControl, timingPolarityControl, loopbackControl, rd;
  int n_errors = 0;
  int n_compared = 0;
  int k;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} shrp_row_t;
  // Ordinary cases: address, value written, value read back.
  shrp_row_t rows[10] = '{'{ADDR_INTERRUPT_ENABLE, 8'hFF, 8'h1F}, '{ADDR_CLOCK_FIFO_CONTROL, 8'hFF, 8'h5F},
    '{ADDR_TIMING_POLARITY_CONTROL, 8'hFF, 8'h7D}, '{ADDR_LOOPBACK_CONTROL, 8'hFF, 8'h07},
    '{ADDR_LIVE_STATUS, 8'hFF, 8'h00}, '{ADDR_INTERRUPT_STATUS, 8'hFF, 8'h00}, '{6'h06, 8'hFF, 8'h00},
    '{6'h3D, 8'hFF, 8'h00}, '{ADDR_DEVICE_IDENTITY, 8'h00, 8'hA5}, '{ADDR_REVISION_IDENTITY, 8'hFF, 8'h01}};
  shrp_port #(.DEVICE_IDENTITY(8'hA5), .REVISION_IDENTITY(8'h01), .RESET_HOLD(HOLD)) uut (.ref_clk(ref_clk), .rst(rst),
    .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serial_in(serial_in), .serial_out(serial_out),
    .serialOutEn(serialOutEn), .resetPin_n(resetPin_n), .osc_locked(src[4]), .sig_loss_now(src[3]),
    .recovery_locked(src[2]), .multiplier_locked(src[1]), .overflow_now(src[0]), .interrupt_n(interrupt_n),
    .clockFifoControl(clockFifoControl), .timingPolarityControl(timingPolarityControl),
    .loopbackControl(loopbackControl));
  shrp_host_model host (.chipSelect_n(chipSelect_n), .serialClock(serialClock), .serial_in(serial_in),
    .serial_out(serial_out));
  // Shared comparison, verdict and access tasks.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int n = 16);
    logic [7:0] q;
    host.xfer(1'b0, a, d, n, q);
  endtask : wr
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Watchdog: a hang counts as a mismatch.
  initial begin
    #400000;
    n_errors++;
    $display("mismatch at %0t: run hung", $time);
    give_verdict();
  end
  // Main sequence: reset, table, then the awkward cases.
  initial begin
    rst = 1'b1;
    resetPin_n = 1'b1;
    src = 5'h00;
    cycles(2);
    rst = 1'b0;
    cycles(4);
    host.xfer(1'b1, ADDR_INTERRUPT_ENABLE, 8'h3C, 16, rd);
    check(rd, 8'h00, "enable reset");
    check(clockFifoControl | timingPolarityControl | loopbackControl, 8'h00, "control reset");
    check({7'h00, interrupt_n}, 8'h01, "interrupt idle");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      host.xfer(1'b1, rows[i].a, 8'hC3, 16, rd);
      check(rd, rows[i].e, "register row");
    end
    check(timingPolarityControl, 8'h7D, "timing port");
    $display("test table done");
    // Short frames are dropped; an uneven value shows the bit order.
    wr(ADDR_LOOPBACK_CONTROL, 8'h00, 10);
    wr(ADDR_LOOPBACK_CONTROL, 8'h00, 15);
    check(loopbackControl, 8'h07, "short frame");
    wr(ADDR_LOOPBACK_CONTROL, 8'hF5);
    check(loopbackControl, 8'h05, "bit order");
    $display("test frames done");
    // Enabled source change raises the interrupt until status is read.
    src = 5'h04;
    for (k = 0; k < 20 && interrupt_n !== 1'b0; k++) cycles(1);
    check({7'h00, interrupt_n}, 8'h00, "interrupt raised");
    host.xfer(1'b1, ADDR_LIVE_STATUS, 8'h00, 16, rd);
    check(rd, 8'h04, "live status");
    check({7'h00, serialOutEn}, 8'h00, "output released");
    host.xfer(1'b1, ADDR_INTERRUPT_STATUS, 8'h00, 16, rd);
    check(rd, 8'h04, "status latched");
    check({7'h00, interrupt_n}, 8'h01, "interrupt cleared");
    // Masked source and lock detect off keep the interrupt quiet.
    wr(ADDR_INTERRUPT_ENABLE, 8'h1D);
    wr(ADDR_TIMING_POLARITY_CONTROL, 8'h7C);
    src = 5'h16;
    cycles(20);
    check({7'h00, interrupt_n}, 8'h01, "masked interrupt");
    host.xfer(1'b1, ADDR_INTERRUPT_STATUS, 8'h00, 16, rd);
    check(rd, 8'h02, "masked status");
    $display("test interrupt done");
    // A short pin pulse is ignored, a long one restores defaults.
    resetPin_n = 1'b0;
    cycles(HOLD / 2);
    resetPin_n = 1'b1;
    cycles(5);
    check(loopbackControl, 8'h05, "short pin pulse");
    resetPin_n = 1'b0;
    cycles(HOLD + 20);
    resetPin_n = 1'b1;
    cycles(5);
    check(loopbackControl, 8'h00, "pin reset");
    host.xfer(1'b1, ADDR_INTERRUPT_ENABLE, 8'h00, 16, rd);
    check(rd, 8'h00, "enable after pin");
    $display("test reset pin done");
    give_verdict();
  end
endmodule : shrp_port_tb
bind shrp_port shrp_port_properties #(.RESET_HOLD(RESET_HOLD)) props (.ref_clk(ref_clk), .rst(rst),
  .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serial_in(serial_in), .serial_out(serial_out),
  .serialOutEn(serialOutEn), .resetPin_n(resetPin_n), .osc_locked(osc_locked), .sig_loss_now(sig_loss_now),
  .recovery_locked(recovery_locked), .multiplier_locked(multiplier_locked), .overflow_now(overflow_now),
  .interrupt_n(interrupt_n), .clockFifoControl(clockFifoControl), .timingPolarityControl(timingPolarityControl),
  .loopbackControl(loopbackControl));
